// file: inc/sgwl_pkg.sv
// Purpose: Shared constants for the serial gain word loader link.
// Assumes: Gain figures are carried in tenths of a milli-dB.
// Notes: The host, the gain decoder and the bench checks use these names through sgwl_pkg::.
package sgwl_pkg;
   // ----------------------------------------------------------------
   // Word format
   // ----------------------------------------------------------------
   localparam int WORD_BITS = 8;
   localparam int CODE_BITS = 7;
   localparam logic [6:0] CODE_MAX = 7'h47;
   localparam logic [6:0] CODE_DEFAULT = 7'h00;
   // ----------------------------------------------------------------
   // Gain figures, in milli-dB scaled by ten (0.1 mdB units)
   // ----------------------------------------------------------------
   localparam int GAIN_MAX_UMDB = 275000;
   localparam int GAIN_STEP_UMDB = 7526;
   localparam int GAIN_W = 20;
   // ----------------------------------------------------------------
   // Host controller timing, in ns and in its own clock cycles
   // ----------------------------------------------------------------
   localparam int SCLK_HALF_NS = 40;
   localparam int CLK_NS = 10;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
   // ----------------------------------------------------------------
   // Host register map, byte offsets on the software port
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_GAIN = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam int CTRL_TXDIS_N_BIT = 0;
   localparam int CTRL_SLEEP_N_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
endpackage : sgwl_pkg

// file: inc/sgwl_if.sv
// Purpose: Three-wire gain link plus the two asynchronous mode lines.
// Assumes: The host drives every signal; the device only listens.
// Notes: No clocking block; the bench supplies nothing here.
`timescale 1ns/1ps
interface sgwl_if;
   logic load_window_n;      // Framing strobe, low during a load.
   logic serial_clk;         // Serial clock from the host.
   logic serial_gain_in;     // Serial data, MSB first.
   logic transmit_disable_n; // Low: between-burst mode.
   logic sleep_n;            // Low: sleep, high output impedance.
   modport host (
      output load_window_n,
      output serial_clk,
      output serial_gain_in,
      output transmit_disable_n,
      output sleep_n
   );
   modport device (
      input load_window_n,
      input serial_clk,
      input serial_gain_in,
      input transmit_disable_n,
      input sleep_n
   );
endinterface : sgwl_if

// file: logic/sgwl_gain_decode.sv
// Purpose: Map a held gain code to a gain figure in 0.1 mdB units.
// Assumes: The code is the seven retained bits; the eighth never arrives.
// Notes: Purely combinational; used by the device end.
`timescale 1ns/1ps
module sgwl_gain_decode (
   input wire logic [6:0] i_code,                 // Held gain code.
   output logic signed [sgwl_pkg::GAIN_W-1:0] o_gain, // Gain, 0.1 mdB.
   output logic o_valid                           // Code in usual range.
);
   localparam int GAIN_W = sgwl_pkg::GAIN_W;
   logic [6:0] eff;
   always_comb begin
      // Above the top code only the vernier steps move, so the low three
      // bits repeat against the top coarse setting.
      if (i_code > sgwl_pkg::CODE_MAX) begin
         eff = {4'h8, i_code[2:0]} - 7'h01;
         if (i_code[2:0] == 3'h0) begin
            eff = 7'h40;
         end
      end else begin
         eff = i_code;
      end
      o_gain = GAIN_W'(sgwl_pkg::GAIN_MAX_UMDB
               - sgwl_pkg::GAIN_STEP_UMDB
               * (int'(sgwl_pkg::CODE_MAX) - int'(eff)));
      o_valid = (i_code <= sgwl_pkg::CODE_MAX);
   end
endmodule : sgwl_gain_decode

// file: logic/sgwl_device.sv
// Purpose: Device end: seven-bit shift register and gain latch.
// Assumes: Clocked only by the link's serial clock and strobe edges.
// Notes: No system reset; the latch is unknown until the first load.
`timescale 1ns/1ps
module sgwl_device (
   sgwl_if.device lnk,                         // Link from the host.
   output logic [6:0] o_gain_code,             // Latched gain code.
   output logic signed [19:0] o_gain,          // Gain, 0.1 mdB units.
   output logic o_code_valid,                  // Code within 0..71.
   output logic o_between_burst,               // Transmission stopped.
   output logic o_sleep                        // Low power, high Z out.
);
   // ----------------------------------------------------------------
   // Shift register, master and slave stages
   // ----------------------------------------------------------------
   logic master;
   logic [6:0] slave;
   logic [6:0] next_slave;
   logic [6:0] latch;
   // The strobe gates clocking, so a stray edge while high is ignored.
   always_ff @(posedge lnk.serial_clk) begin
      if (!lnk.load_window_n) begin
         master <= lnk.serial_gain_in;
      end
   end
   // Shifting left drops the first-sent bit on the eighth clock.
   always_comb begin
      next_slave = {slave[5:0], master};
   end
   always_ff @(negedge lnk.serial_clk) begin
      if (!lnk.load_window_n) begin
         slave <= next_slave;
      end
   end
   // ----------------------------------------------------------------
   // Gain latch, no reset value on purpose
   // ----------------------------------------------------------------
   always_ff @(posedge lnk.load_window_n) begin
      latch <= slave;
   end
   assign o_gain_code = latch;
   sgwl_gain_decode u_dec (
      .i_code(latch),
      .o_gain(o_gain),
      .o_valid(o_code_valid)
   );
   assign o_between_burst = !lnk.transmit_disable_n;
   assign o_sleep = !lnk.sleep_n;
endmodule : sgwl_device

// file: logic/sgwl_host.sv
// Purpose: Host end: registers for software, serialiser for gain words.
// Assumes: Serial clock made by dividing i_clk; mode lines are registers.
// Notes: A write to the gain register while busy is dropped.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module sgwl_host (
   input wire logic i_clk,            // System clock, 100 MHz.
   input wire logic i_rst_n,          // Synchronous reset, active low.
   input wire logic [3:0] i_addr,     // Register byte address.
   input wire logic [31:0] i_wdata,   // Write data.
   input wire logic i_wr,             // Write strobe.
   input wire logic i_rd,             // Read strobe.
   output logic [31:0] o_rdata,       // Read data, cycle after strobe.
   sgwl_if.host lnk                   // Link to the device.
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SGWL_IDLE = 4'b0001,
      SGWL_LOW = 4'b0010,
      SGWL_HIGH = 4'b0100,
      SGWL_END = 4'b1000
   } sgwl_state_t;
   sgwl_state_t state, next_state;
   logic [7:0] word, next_word;
   logic [7:0] shreg, next_shreg;
   logic [3:0] half, next_half;
   logic [3:0] bitn, next_bitn;
   logic [1:0] ctrl, next_ctrl;
   logic done, next_done;
   logic win_n, next_win_n;
   logic sclk, next_sclk;
   logic sdo, next_sdo;
   logic [31:0] rdata, next_rdata;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction : hit

   always_comb begin
      next_state = state;
      next_word = word;
      next_shreg = shreg;
      next_half = half;
      next_bitn = bitn;
      next_ctrl = ctrl;
      next_done = done;
      next_win_n = win_n;
      next_sclk = sclk;
      next_sdo = sdo;
      next_rdata = 32'h0000_0000;
      if (i_wr && hit(i_addr, sgwl_pkg::REG_CTRL)) begin
         next_ctrl = i_wdata[1:0];
      end
      if (i_rd) begin
         case (i_addr)
            sgwl_pkg::REG_GAIN: next_rdata = {24'h00_0000, word};
            sgwl_pkg::REG_CTRL: next_rdata = {30'h0000_0000, ctrl};
            sgwl_pkg::REG_STAT:
               next_rdata = {30'h0000_0000, done, state != SGWL_IDLE};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      // Set wins over the read-clear of the done flag.
      if (i_rd && hit(i_addr, sgwl_pkg::REG_STAT)) begin
         next_done = 1'b0;
      end
      case (state)
         SGWL_IDLE: begin
            if (i_wr && hit(i_addr, sgwl_pkg::REG_GAIN)) begin
               next_word = i_wdata[7:0];
               next_shreg = i_wdata[7:0];
               next_win_n = 1'b0;
               next_sdo = i_wdata[7];
               next_bitn = 4'h0;
               next_half = 4'h0;
               next_state = SGWL_LOW;
            end
         end
         SGWL_LOW: begin
            next_half = half + 4'h1;
            if (half == sgwl_pkg::HALF_LAST) begin
               next_half = 4'h0;
               next_sclk = 1'b1;
               next_state = SGWL_HIGH;
            end
         end
         SGWL_HIGH: begin
            next_half = half + 4'h1;
            if (half == sgwl_pkg::HALF_LAST) begin
               next_half = 4'h0;
               next_sclk = 1'b0;
               next_shreg = {shreg[6:0], 1'b0};
               next_sdo = shreg[6];
               next_bitn = bitn + 4'h1;
               next_state = SGWL_LOW;
               if (bitn == 4'(sgwl_pkg::WORD_BITS - 1)) begin
                  next_state = SGWL_END;
               end
            end
         end
         SGWL_END: begin
            next_half = half + 4'h1;
            if (half == sgwl_pkg::HALF_LAST) begin
               next_half = 4'h0;
               next_win_n = 1'b1;
               next_done = 1'b1;
               next_state = SGWL_IDLE;
            end
         end
         default: next_state = SGWL_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= SGWL_IDLE;
         word <= 8'h00;
         shreg <= 8'h00;
         half <= 4'h0;
         bitn <= 4'h0;
         ctrl <= sgwl_pkg::CTRL_RESET;
         done <= 1'b0;
         win_n <= 1'b1;
         sclk <= 1'b0;
         sdo <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         word <= next_word;
         shreg <= next_shreg;
         half <= next_half;
         bitn <= next_bitn;
         ctrl <= next_ctrl;
         done <= next_done;
         win_n <= next_win_n;
         sclk <= next_sclk;
         sdo <= next_sdo;
         rdata <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign lnk.load_window_n = win_n;
   assign lnk.serial_clk = sclk;
   assign lnk.serial_gain_in = sdo;
   assign lnk.transmit_disable_n = ctrl[sgwl_pkg::CTRL_TXDIS_N_BIT];
   assign lnk.sleep_n = ctrl[sgwl_pkg::CTRL_SLEEP_N_BIT];
endmodule : sgwl_host

// file: tb/sgwl_properties.sv
// Purpose: Concurrent checks on the gain link and the device outputs.
// Assumes: Host clock far faster than the serial clock it divides down.
// Notes: Latch checks wait for a finished load; the latch starts unknown.
`timescale 1ns/1ps
module sgwl_properties (
   input wire logic i_clk,                // Host clock.
   input wire logic i_rst_n,              // Host reset, active low.
   input wire logic load_window_n,        // Framing strobe.
   input wire logic serial_clk,           // Serial clock.
   input wire logic serial_gain_in,       // Serial data.
   input wire logic transmit_disable_n,   // Between-burst control.
   input wire logic sleep_n,              // Sleep control.
   input wire logic [6:0] o_gain_code,    // Latched code.
   input wire logic signed [19:0] o_gain, // Decoded gain.
   input wire logic o_code_valid,         // Code in range.
   input wire logic o_between_burst,      // Mode output.
   input wire logic o_sleep               // Mode output.
);
   logic [6:0] shadow;
   logic [3:0] rises;
   logic loaded;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ----------------------------------------------------------------
   // Reference shifter, kept seven bits deep like the device.
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         shadow <= 7'h00;
         rises <= 4'h0;
         loaded <= 1'b0;
      end else begin
         if ($rose(serial_clk)) shadow <= {shadow[5:0], serial_gain_in};
         if ($fell(load_window_n)) rises <= 4'h0;
         else if ($rose(serial_clk)) rises <= rises + 4'h1;
         if ($rose(load_window_n)) loaded <= 1'b1;
      end
   end
   chk_burst_mode: assert property (
      o_between_burst == !transmit_disable_n)
      else $error("between-burst output wrong");
   chk_sleep_mode: assert property (
      o_sleep == !sleep_n)
      else $error("sleep output wrong");
   chk_clock_idle: assert property (
      load_window_n |-> !serial_clk)
      else $error("serial clock moved outside a frame");
   chk_eight_clocks: assert property (
      $rose(load_window_n) |-> rises == 8)
      else $error("frame did not carry eight clocks");
   chk_latch_word: assert property (
      $rose(load_window_n) |=> o_gain_code == shadow)
      else $error("latched code differs from last seven bits");
   chk_data_setup: assert property (
      $rose(serial_clk) |-> $stable(serial_gain_in))
      else $error("serial data changed at the sampling edge");
   chk_gain_hold: assert property (
      loaded && !load_window_n |-> $stable(o_gain_code))
      else $error("gain changed during a load");
   chk_code_flag: assert property (
      loaded |-> o_code_valid == (o_gain_code <= sgwl_pkg::CODE_MAX))
      else $error("code valid flag wrong");
   chk_gain_value: assert property (
      loaded && o_code_valid |-> int'(o_gain) == sgwl_pkg::GAIN_MAX_UMDB
         - sgwl_pkg::GAIN_STEP_UMDB * (71 - int'(o_gain_code)))
      else $error("gain figure wrong");
   cover property ($rose(load_window_n) && loaded);
   cover property (loaded && !o_code_valid);
   cover property ($rose(transmit_disable_n));
endmodule : sgwl_properties

// file: tb/sgwl_tb.sv
// Purpose: Drives the host registers and checks words arriving at the device.
// Assumes: Host makes the serial clock; the bench drives only i_clk, i_rst_n and the register port.
// Notes: Each word written through send is noted; a monitor checks it at strobe rise.
`timescale 1ns/1ps
module sgwl_tb;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic [6:0] o_gain_code;
   logic signed [19:0] o_gain;
   logic o_code_valid;
   logic o_between_burst;
   logic o_sleep;
   logic [7:0] notes[$];
   logic [7:0] wire_word = 8'h00;
   logic [31:0] rd_val;
   int nclk = 0;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 32'h8ff1;
   sgwl_if lnk ();
   sgwl_host sgwl_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .lnk(lnk.host));
   sgwl_device sgwl_device_inst (.lnk(lnk.device), .o_gain_code(o_gain_code),
      .o_gain(o_gain), .o_code_valid(o_code_valid),
      .o_between_burst(o_between_burst), .o_sleep(o_sleep));
   sgwl_properties sgwl_properties_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .load_window_n(lnk.load_window_n), .serial_clk(lnk.serial_clk),
      .serial_gain_in(lnk.serial_gain_in), .sleep_n(lnk.sleep_n),
      .transmit_disable_n(lnk.transmit_disable_n), .o_gain(o_gain),
      .o_gain_code(o_gain_code), .o_code_valid(o_code_valid),
      .o_between_burst(o_between_burst), .o_sleep(o_sleep));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd
   // A word is noted only once the host is idle, since busy drops writes.
   task automatic send(input logic [7:0] w);
      int n = 0;
      rd(sgwl_pkg::REG_STAT, rd_val);
      while (rd_val[0] !== 1'b0 && n < 100) begin
         rd(sgwl_pkg::REG_STAT, rd_val);
         n++;
      end
      if (n >= 100) mismatches++;
      notes.push_back(w);
      wr(sgwl_pkg::REG_GAIN, {24'h00_0000, w});
   endtask : send
   initial forever #5 i_clk = ~i_clk;
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
   always @(posedge lnk.serial_clk) begin
      nclk++;
      wire_word = {wire_word[6:0], lnk.serial_gain_in};
   end
   always @(negedge lnk.load_window_n) nclk = 0;
   // ----------------------------------------------------------------
   // Monitor
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] e;
      int g;
      int eg;
      @(posedge i_rst_n);
      forever begin
         @(posedge lnk.load_window_n);
         #1;
         e = (notes.size() > 0) ? notes.pop_front() : 8'hxx;
         chk(wire_word, e);
         chk(nclk, 8);
         chk(lnk.serial_clk, 0);
         chk(o_gain_code, e[6:0]);
         chk(o_code_valid, e[6:0] <= sgwl_pkg::CODE_MAX);
         // Above the top code only the fine steps move, so each group of
         // eight codes restarts near the top coarse setting.
         if (e[6:0] <= sgwl_pkg::CODE_MAX) begin
            g = int'(e[6:0]);
         end else if (e[2:0] == 3'h0) begin
            g = 64;
         end else begin
            g = 63 + int'(e[2:0]);
         end
         eg = sgwl_pkg::GAIN_MAX_UMDB - sgwl_pkg::GAIN_STEP_UMDB * (71 - g);
         chk(o_gain, eg);
      end
   end
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      chk({o_sleep, o_between_burst}, 32'h0000_0003);
      rd(sgwl_pkg::REG_CTRL, rd_val);
      chk(rd_val, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
         wr(sgwl_pkg::REG_CTRL, 32'(m));
         repeat (2) @(posedge i_clk);
         #1;
         chk({o_sleep, o_between_burst}, 32'(~m & 3));
      end
      rd(4'hc, rd_val);
      chk(rd_val, 32'h0000_0000);
      send(8'h47);
      wr(sgwl_pkg::REG_GAIN, 32'h0000_0011);
      rd(sgwl_pkg::REG_STAT, rd_val);
      chk(rd_val[0], 1);
      send(8'h00);
      send(8'hc7);
      send(8'h48);
      send(8'hff);
      for (int k = 0; k < 6; k++) send(8'($random(seed)));
      repeat (100) @(posedge i_clk);
      rd(sgwl_pkg::REG_STAT, rd_val);
      chk(rd_val[1:0], 2);
      rd(sgwl_pkg::REG_STAT, rd_val);
      chk(rd_val[1:0], 0);
      chk(notes.size(), 0);
      end_sim();
   end
endmodule : sgwl_tb
